// File: include/fast_timer_defines.svh
// Register offsets, field positions, reset values and fixed codes of the fast timer clock block.
`ifndef FAST_TIMER_DEFINES_SVH
`define FAST_TIMER_DEFINES_SVH

// ****************************************
// Register offsets on the CPU I/O space
// ****************************************
`define ADDR_PLL_CONTROL_STATUS   6'h29
`define ADDR_TIMER1_CLOCK_CONTROL 6'h2F
`define ADDR_COUNTER_VALUE        6'h2E
`define ADDR_UPPER_BITS_BUFFER    6'h1B

// ****************************************
// Field positions
// ****************************************
`define BIT_LOW_SPEED_SELECT  7
`define BIT_FAST_CLOCK_SELECT 2
`define BIT_PLL_ON            1
`define BIT_PLL_LOCK_FLAG     0
`define BIT_PRESCALER_CLEAR   6
`define CLOCK_SELECT_MSB      3

// ****************************************
// Reset values and fixed codes
// ****************************************
`define RESET_CLOCK_SELECT    4'h0
`define RESET_COUNTER_VALUE   10'h000
`define RESET_UPPER_BUFFER    2'h0
`define FUSE_PLL_CLOCK        4'h1
`define CLOCK_SELECT_STOP     4'h0

`endif

// File: include/fast_timer_pkg.sv
// Types shared by the fast timer clock block.
package fast_timer_pkg;

    // Timer clocking mode chosen by the fast clock select bit.
    typedef enum logic
    {
        SYNC_MODE  = 1'b0,
        ASYNC_MODE = 1'b1
    } clock_mode_type;

    typedef logic [3:0] clock_select_type;

endpackage : fast_timer_pkg

// File: rtl/timer_prescaler.sv
// Free-running 14-bit prescaler with tap selection for the timer clock enable.
`include "fast_timer_defines.svh"

module timer_prescaler
    import fast_timer_pkg::*;
#(
    parameter int DIV_WIDTH = 14
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Source and control
    input  wire logic             sourceTick,
    input  wire logic             prescalerClear,
    input  wire clock_select_type clockSelect,
    // Timer clock enable
    output logic                  timerTick
);

    // ****************************************
    // Elaboration check
    // ****************************************
    if (DIV_WIDTH != 14)
    begin : g_width_check
        $error("timer_prescaler serves only a 14-bit divider");
    end

    // ****************************************
    // Tap decode
    // ****************************************

    // Mask of low divider bits that must all be one for code n: 2^(n-1)-1.
    function automatic logic [DIV_WIDTH-1:0] tap_mask(input clock_select_type code);
        logic [DIV_WIDTH:0] full;
        full = '0;
        if (code != `CLOCK_SELECT_STOP)
        begin
            full = ((DIV_WIDTH+1)'(1) << (code - 4'h1)) - (DIV_WIDTH+1)'(1);
        end
        return full[DIV_WIDTH-1:0];
    endfunction : tap_mask

    logic [DIV_WIDTH-1:0] divider;
    wire  [DIV_WIDTH-1:0] mask      = tap_mask(clockSelect);
    wire                  running   = clockSelect != `CLOCK_SELECT_STOP;
    wire                  next_tick = running && sourceTick && ((divider & mask) == mask);

    // Divider counts source ticks; a clear restarts the division phase at once.
    // free-running divider
    always_ff @(posedge clk)
    begin
        if (rst || prescalerClear)
            divider <= '0;
        else if (sourceTick)
            divider <= divider + DIV_WIDTH'(1);
    end

    // Registered so the enable reaches the counter glitch free.
    always_ff @(posedge clk)
    begin
        if (rst)
            timerTick <= 1'b0;
        else
            timerTick <= next_tick;
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    stop_no_tick_a: assert property (clockSelect == `CLOCK_SELECT_STOP |=> !timerTick)
        else $error("Timer ticked while clock select was stop");
    undivided_tick_a: assert property ((clockSelect == 4'h1) && sourceTick && !prescalerClear |=> timerTick)
        else $error("Undivided code missed a source tick");
    clear_restart_a: assert property (prescalerClear |=> divider == '0)
        else $error("Prescaler clear did not restart the divider");
    div2_cover: cover property ((clockSelect == 4'h2) && timerTick ##[1:8] timerTick);

endmodule : timer_prescaler

// File: rtl/fast_timer_clock.sv
// PLL control, clock select, prescaler and 10-bit access buffer of the fast timer.
// How it works
// - Low-speed select halves the fast clock
// - Low-speed refused while PLL is system clock
// - PLL status bits 6 to 3 read zero
// - Fast select picks fast or system clock
// - Fast select accepts one only with PLL enabled
// - PLL-on starts PLL; reads one if system clock
// - Lock flag shows PLL locked state
// - Prescaler clear resets prescaler, reads zero
// - Clock select zero stops the timer
// - Codes 1-15 divide by two powers
// - Timer registers are ten bits wide
// - Low-byte read copies upper bits to buffer
// - Low-byte write loads upper bits from buffer
// - Fast clock drives timer up to 64 MHz
`include "fast_timer_defines.svh"

module fast_timer_clock
    import fast_timer_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // CPU I/O port
    input  wire logic [5:0] ioAddr,
    input  wire logic [7:0] ioWrData,
    input  wire logic       ioWrite,
    input  wire logic       ioRead,
    output logic      [7:0] ioRdData,
    // PLL and fuse
    input  wire logic [3:0] clockSourceFuse,
    input  wire logic       pllLockRaw,
    input  wire logic       fastPeripheralTick,
    output logic            pllEnable,
    // Timer
    output logic            timerTick,
    output logic      [9:0] counterValue,
    output clock_mode_type  clockMode
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [3:0] fuseMeta;
    logic [3:0] fuseSync;
    logic       lockMeta;
    logic       pllLockFlag;

    // Fuse and lock come from outside this clock domain.
    always_ff @(posedge clk)
    begin
        fuseMeta    <= clockSourceFuse;
        fuseSync    <= fuseMeta;
        lockMeta    <= pllLockRaw;
        pllLockFlag <= lockMeta;
    end

    // ****************************************
    // Register decode
    // ****************************************
    logic             lowSpeedSelect;
    logic             fastClockSelect;
    logic             pllOnBit;
    clock_select_type clockSelectField;
    logic       [1:0] upperBitsBuffer;
    logic             prescalerClear;
    logic             halfPhase;

    wire wrPll     = ioWrite && (ioAddr == `ADDR_PLL_CONTROL_STATUS);
    wire wrControl = ioWrite && (ioAddr == `ADDR_TIMER1_CLOCK_CONTROL);
    wire wrCounter = ioWrite && (ioAddr == `ADDR_COUNTER_VALUE);
    wire wrUpper   = ioWrite && (ioAddr == `ADDR_UPPER_BITS_BUFFER);
    wire rdCounter = ioRead && (ioAddr == `ADDR_COUNTER_VALUE);

    wire pllIsSystemClock = fuseSync == `FUSE_PLL_CLOCK;
    wire pllOnRead        = pllOnBit || pllIsSystemClock;
    wire pllEnabled       = pllOnRead;

    // Write acceptance of the guarded bits.
    // low-speed refused
    wire next_lowSpeed  = ioWrData[`BIT_LOW_SPEED_SELECT] && !pllIsSystemClock;
    wire next_fastClock = ioWrData[`BIT_FAST_CLOCK_SELECT] && pllEnabled;

    wire [7:0] pllStatusRead = {lowSpeedSelect, 4'h0, fastClockSelect, pllOnRead, pllLockFlag};
    wire [7:0] controlRead   = {4'h0, clockSelectField};

    wire [7:0] next_rdData =
        (ioAddr == `ADDR_PLL_CONTROL_STATUS)   ? pllStatusRead :
        (ioAddr == `ADDR_TIMER1_CLOCK_CONTROL) ? controlRead :
        (ioAddr == `ADDR_COUNTER_VALUE)        ? counterValue[7:0] :
        (ioAddr == `ADDR_UPPER_BITS_BUFFER)    ? {6'h00, upperBitsBuffer} : 8'h00;

    // ****************************************
    // Control registers
    // ****************************************

    // PLL control and status; the PLL-on bit also drives the pllEnable output.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lowSpeedSelect  <= 1'b0;
            fastClockSelect <= 1'b0;
            pllOnBit        <= 1'b0;
        end
        else if (wrPll)
        begin
            lowSpeedSelect  <= next_lowSpeed;
            fastClockSelect <= next_fastClock;
            pllOnBit        <= ioWrData[`BIT_PLL_ON];
        end
    end

    // Clock select field and the self-clearing prescaler clear pulse.
    // one-cycle clear pulse
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            clockSelectField <= `RESET_CLOCK_SELECT;
            prescalerClear   <= 1'b0;
        end
        else
        begin
            prescalerClear <= wrControl && ioWrData[`BIT_PRESCALER_CLEAR];
            if (wrControl)
                clockSelectField <= ioWrData[`CLOCK_SELECT_MSB:0];
        end
    end

    // Read data is registered: it appears the cycle after the read strobe.
    always_ff @(posedge clk)
    begin
        if (rst)
            ioRdData <= 8'h00;
        else if (ioRead)
            ioRdData <= next_rdData;
    end

    // ****************************************
    // Clock source selection
    // ****************************************

    // Low-speed mode passes every other fast tick; the trade is half rate for safe timing.
    // halve the fast clock
    always_ff @(posedge clk)
    begin
        if (rst)
            halfPhase <= 1'b0;
        else if (fastPeripheralTick)
            halfPhase <= !halfPhase;
    end

    assign clockMode  = fastClockSelect ? ASYNC_MODE : SYNC_MODE;
    wire   fastSource = fastPeripheralTick && (!lowSpeedSelect || halfPhase);
    wire   sourceTick = (clockMode == ASYNC_MODE) ? fastSource : 1'b1;
    assign pllEnable  = pllEnabled;

    timer_prescaler #(
        .DIV_WIDTH      (14)
    ) u_prescaler (
        .clk            (clk),
        .rst            (rst),
        .sourceTick     (sourceTick),
        .prescalerClear (prescalerClear),
        .clockSelect    (clockSelectField),
        .timerTick      (timerTick)
    );

    // ****************************************
    // Ten-bit counter and upper bits buffer
    // ****************************************

    // A CPU write to the low byte beats counting; the upper bits come from the buffer.
    // ten-bit counter
    always_ff @(posedge clk)
    begin
        if (rst)
            counterValue <= `RESET_COUNTER_VALUE;
        else if (wrCounter)
            counterValue <= {upperBitsBuffer, ioWrData};
        else if (timerTick)
            counterValue <= counterValue + 10'h001;
    end

    // Shared buffer: written directly, or captured by a low-byte read.
    // capture on low read
    always_ff @(posedge clk)
    begin
        if (rst)
            upperBitsBuffer <= `RESET_UPPER_BUFFER;
        else if (wrUpper)
            upperBitsBuffer <= ioWrData[1:0];
        else if (rdCounter)
            upperBitsBuffer <= counterValue[9:8];
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    lowspeed_refused_a: assert property (wrPll && pllIsSystemClock |=> !lowSpeedSelect)
        else $error("Low-speed select set while PLL is system clock");
    reserved_zero_a: assert property (ioRead && ioAddr == `ADDR_PLL_CONTROL_STATUS |=> ioRdData[6:3] == 4'h0)
        else $error("Reserved PLL status bits read nonzero");
    fast_refused_a: assert property (wrPll && !pllEnabled |=> clockMode == SYNC_MODE)
        else $error("Fast clock select accepted without PLL");
    pll_on_forced_a: assert property (pllIsSystemClock && ioRead && ioAddr == `ADDR_PLL_CONTROL_STATUS
        |=> ioRdData[`BIT_PLL_ON] && pllEnable)
        else $error("PLL-on not read as one while PLL is system clock");
    lock_sync_a: assert property ($rose(pllLockRaw) ##1 pllLockRaw |=> pllLockFlag)
        else $error("Lock flag did not follow the synchronised lock");
    clear_reads_zero_a: assert property (ioRead && ioAddr == `ADDR_TIMER1_CLOCK_CONTROL |=> ioRdData[7:4] == 4'h0)
        else $error("Prescaler clear bit read as one");
    low_write_load_a: assert property (wrCounter |=> counterValue == {$past(upperBitsBuffer), $past(ioWrData)})
        else $error("Low-byte write did not load upper bits from buffer");
    read_capture_a: assert property (rdCounter && !wrUpper |=> upperBitsBuffer == $past(counterValue[9:8]))
        else $error("Low-byte read did not capture upper bits");
    half_rate_a: assert property (lowSpeedSelect && clockMode == ASYNC_MODE && clockSelectField == 4'h1
        && fastPeripheralTick && !halfPhase |=> !timerTick)
        else $error("Low-speed mode passed a fast tick it should drop");
    sync_source_a: assert property (clockMode == SYNC_MODE && clockSelectField == 4'h1 |=> timerTick)
        else $error("Synchronous mode lost the system clock source");

    async_cover: cover property (wrPll && next_fastClock ##1 clockMode == ASYNC_MODE);
    ten_bit_cover: cover property (wrCounter && upperBitsBuffer != 2'h0);
    lowspeed_cover: cover property (wrPll && next_lowSpeed);

endmodule : fast_timer_clock

// File: sim/fast_timer_clock_prescaler_tb.sv
// Self-checking testbench of the fast timer clock, prescaler and ten-bit access buffer.
`include "fast_timer_defines.svh"

module fast_timer_clock_prescaler_tb
    import fast_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Signals, clock and stimulus helpers
    // ****************************************
    logic           clk                = 1'b0;
    logic           rst                = 1'b1;
    logic     [5:0] ioAddr             = 6'h00;
    logic     [7:0] ioWrData           = 8'h00;
    logic           ioWrite            = 1'b0;
    logic           ioRead             = 1'b0;
    logic     [7:0] ioRdData;
    logic     [3:0] clockSourceFuse    = 4'h0;
    logic           pllLockRaw         = 1'b0;
    logic           fastPeripheralTick = 1'b0;
    logic           pllEnable;
    logic           timerTick;
    logic     [9:0] counterValue;
    clock_mode_type clockMode;
    int             err_count          = 0;
    int             checked            = 0;
    int             cycles             = 0;
    int             fastPeriod         = 0;
    int             fastCount          = 0;
    logic    [31:0] rnd                = 32'h795F_CC1E;

    fast_timer_clock DUT
    (
        .clk, .rst,
        .ioAddr, .ioWrData, .ioWrite, .ioRead, .ioRdData,
        .clockSourceFuse, .pllLockRaw, .fastPeripheralTick, .pllEnable,
        .timerTick, .counterValue, .clockMode
    );

    // The 100 MHz system clock.
    initial
    begin
        forever #5 clk = ~clk;
    end

    // Fast clock enable pulses, one every fastPeriod cycles; zero keeps it still.
    // The fast clock arrives as enables of this clock, so the crossing rate limit holds by construction.
    // fast tick spacing
    always @(posedge clk)
    begin
        fastCount <= (fastCount + 1 >= fastPeriod) ? 0 : fastCount + 1;
        fastPeripheralTick <= (fastPeriod != 0) && (fastCount == 0);
    end

    // Cuts a hang short; the ceiling leaves room above the slowest prescale code.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 95000)
        begin
            err_count++;
            tally_and_finish();
        end
    end

    // ****************************************
    // Tasks and functions
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
    endfunction : lfsr

    task automatic judge(input logic bad, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (bad !== 1'b0)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : judge

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        judge(got !== exp, 32'(got), 32'(exp));
    endtask : cmp8

    task automatic cmp10(input logic [9:0] got, input logic [9:0] exp);
        judge(got !== exp, 32'(got), 32'(exp));
    endtask : cmp10

    task automatic cmpGap(input int got, input int exp);
        judge(got != exp, got, exp);
    endtask : cmpGap

    // A write lowers its strobe and lets one more edge pass, so calls may follow at once.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        ioAddr <= a;
        ioWrData <= d;
        ioWrite <= 1'b1;
        @(posedge clk);
        ioWrite <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        ioAddr <= a;
        ioRead <= 1'b1;
        @(posedge clk);
        ioRead <= 1'b0;
        @(posedge clk);
        d = ioRdData;
    endtask : rd

    task automatic expectReg(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        cmp8(v, exp);
    endtask : expectReg

    // Spacing of two timer ticks, and one count step between them.
    task automatic checkGap(input int exp);
        int         n;
        logic [9:0] first;
        repeat (3) @(posedge clk);
        n = 0;
        while (timerTick !== 1'b1 && n < 40000)
        begin
            @(posedge clk);
            n++;
        end
        first = counterValue;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (timerTick !== 1'b1 && n < 40000);
        cmpGap(n, exp);
        cmp10(counterValue, first + 10'h001);
    endtask : checkGap

    task automatic tally_and_finish();
        $display("compares %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        logic [7:0] v;
        logic [9:0] val;
        int         n;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset values, and an unmapped address reading zero.
        expectReg(`ADDR_PLL_CONTROL_STATUS, 8'h00);
        expectReg(`ADDR_TIMER1_CLOCK_CONTROL, 8'h00);
        expectReg(6'h3F, 8'h00);
        // Ten-bit counter through the shared buffer, corners first, timer stopped.
        for (int i = 0; i < 6; i++)
        begin
            val = (i == 0) ? 10'h3FF : (i == 1) ? 10'h100 : rnd[9:0];
            rnd = lfsr(rnd);
            wr(`ADDR_UPPER_BITS_BUFFER, {6'h00, val[9:8]});
            wr(`ADDR_COUNTER_VALUE, val[7:0]);
            cmp10(counterValue, val);
            wr(`ADDR_UPPER_BITS_BUFFER, 8'h00);
            expectReg(`ADDR_COUNTER_VALUE, val[7:0]);
            expectReg(`ADDR_UPPER_BITS_BUFFER, {6'h00, val[9:8]});
        end
        repeat (20) @(posedge clk);
        cmp10(counterValue, val);
        // Every prescale code on the system clock, each restarted by a prescaler clear.
        for (int code = 1; code < 16; code++)
        begin
            wr(`ADDR_TIMER1_CLOCK_CONTROL, 8'h40 | 8'(code));
            checkGap(1 << (code - 1));
        end
        expectReg(`ADDR_TIMER1_CLOCK_CONTROL, 8'h0F);
        // Timer stopped, then fast select refused while the PLL is still off.
        wr(`ADDR_TIMER1_CLOCK_CONTROL, 8'h00);
        wr(`ADDR_PLL_CONTROL_STATUS, 8'hFF);
        expectReg(`ADDR_PLL_CONTROL_STATUS, 8'h82);
        cmp8(8'(pllEnable), 8'h01);
        // A prescaler clear alone must leave the stopped counter where it stands.
        val = counterValue;
        wr(`ADDR_TIMER1_CLOCK_CONTROL, 8'h40);
        cmp10(counterValue, val);
        // Settling wait, then lock polled before the fast clock is chosen.
        repeat (10000) @(posedge clk);
        pllLockRaw <= 1'b1;
        n = 0;
        do
            rd(`ADDR_PLL_CONTROL_STATUS, v);
        while (v[0] !== 1'b1 && ++n < 50);
        cmp8(v, 8'h83);
        fastPeriod <= 3;
        wr(`ADDR_PLL_CONTROL_STATUS, 8'h06);
        cmp8(8'(clockMode), 8'(ASYNC_MODE));
        wr(`ADDR_TIMER1_CLOCK_CONTROL, 8'h01);
        checkGap(3);
        wr(`ADDR_TIMER1_CLOCK_CONTROL, 8'h03);
        checkGap(12);
        // Low speed halves the fast clock; the timer is stopped around the change.
        wr(`ADDR_TIMER1_CLOCK_CONTROL, 8'h00);
        wr(`ADDR_PLL_CONTROL_STATUS, 8'h86);
        wr(`ADDR_TIMER1_CLOCK_CONTROL, 8'h01);
        checkGap(6);
        // Second reset with the PLL strapped as the system clock.
        rst <= 1'b1;
        clockSourceFuse <= 4'h1;
        pllLockRaw <= 1'b0;
        fastPeriod <= 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        expectReg(`ADDR_PLL_CONTROL_STATUS, 8'h02);
        wr(`ADDR_PLL_CONTROL_STATUS, 8'h84);
        expectReg(`ADDR_PLL_CONTROL_STATUS, 8'h06);
        tally_and_finish();
    end

endmodule : fast_timer_clock_prescaler_tb
